/* csm_ctrl.sv */
// Overview of operation
// - Power-on clear low forces power-on reset, or hardware standby if the standby pin is low.
// - Manual clear low with power-on clear high gives manual reset.
// - With standby pin high, power-on clear low gives power-on reset.
// - Standby pin low while power-on clear low enters hardware standby.
// - Sleep instruction halts into sleep or software standby.
// - Leaving reset fetches PC and SP from vectors, then runs.
// - Interrupt pushes PC and SR via SP, fetches vector, jumps.
// - Bus release state grants the bus to the requester.
// - Extension mode 0 makes area zero external with 8-bit bus.
// - Extension mode 1 is unsupported and flagged invalid.
// - Extension mode 2 enables on-chip ROM and area zero.
// - Single chip mode frees all ports, no external address.
// - Clock multiplier one, two or four from upper mode pins.
// - Divided clocks down to system/8192 and peripheral/1024.
// - Halted oscillator input forces twelve timer pins high impedance.
// - Standby also floats the twelve timer pins until released.
// - All eight modules start in module standby until software clears it.
// - Power-on vectors at 0 and 4, manual at 8 and C.
// - Reset processing clears vector base and sets mask to all ones.
`timescale 1ns/1ps
`default_nettype none
module csm_ctrl import csm_pkg::*; (
	input wire logic clk,
	input wire logic power_on_clear_n,
	input wire logic manual_clear_n,
	input wire logic hw_standby_n,
	input wire logic [3:0] mode_select_pins,
	input wire logic flash_write_protect,
	input wire logic osc_input,
	input wire logic sleep_exec,
	input wire logic standby_select,
	input wire logic wake_event,
	input wire logic irq_req,
	input wire logic [31:0] irq_vec_addr,
	input wire logic bus_req,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	input wire logic [31:0] cpu_pc,
	input wire logic [31:0] cpu_sr,
	input wire logic [MSTBY_W-1:0] mstby_clear,
	input wire logic [TIMER_PINS-1:0] timer_out,
	input wire logic [TIMER_PINS-1:0] timer_oe_pfc,
	output logic [3:0] cpu_state,
	output logic por_active,
	output logic man_active,
	output logic hw_standby,
	output logic cpu_halt,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	output logic load_regs,
	output logic [31:0] new_pc,
	output logic [31:0] new_sp,
	output logic [31:0] new_vbr,
	output logic [3:0] new_imask,
	output logic bus_grant,
	output logic [1:0] op_mode,
	output logic mode_invalid,
	output logic flash_wp,
	output logic cs0_external,
	output logic cs0_bus8,
	output logic rom_enable,
	output logic ext_addr_enable,
	output logic [1:0] clk_mul,
	output logic [SYS_DIV_W-1:0] sys_div_clk,
	output logic [PER_DIV_W-1:0] per_div_clk,
	output logic [MSTBY_W-1:0] module_standby,
	output logic [TIMER_PINS-1:0] timer_pin_out,
	output logic [TIMER_PINS-1:0] timer_pin_oe,
	output logic osc_halted
);
	logic rst_n;
	logic por_s;
	logic man_s;
	logic hst_s;
	logic osc_s;
	logic osc_prev;
	logic [OSC_CNT_W-1:0] osc_cnt;
	logic [4:0] mode_s;
	logic is_manual;
	logic [31:0] sp_work;
	logic [31:0] pc_hold;
	csm_state_e state;
	csm_state_e next_state;
	assign rst_n = power_on_clear_n | ~hw_standby_n;

	function automatic logic [31:0] sp_dec(input logic [31:0] sp);
		sp_dec = sp - 32'(SP_STEP);
	endfunction

	csm_sync #(.W(1), .INIT(1'b0)) u_por (
		.clk(clk), .rst_n(rst_n), .din(power_on_clear_n), .dout(por_s));
	csm_sync #(.W(1), .INIT(1'b1)) u_man (
		.clk(clk), .rst_n(rst_n), .din(manual_clear_n), .dout(man_s));
	csm_sync #(.W(1), .INIT(1'b1)) u_hst (
		.clk(clk), .rst_n(rst_n), .din(hw_standby_n), .dout(hst_s));
	csm_sync #(.W(1), .INIT(1'b0)) u_osc (
		.clk(clk), .rst_n(rst_n), .din(osc_input), .dout(osc_s));
	csm_sync #(.W(5), .INIT(5'h00)) u_mode (
		.clk(clk), .rst_n(rst_n), .din({flash_write_protect, mode_select_pins}),
		.dout(mode_s));

	always_comb begin
		next_state = state;
		case (state)
			CSM_POR: begin
				if (por_s) begin
					next_state = CSM_RST_PC;
				end
			end
			CSM_MAN: begin
				if (man_s) begin
					next_state = CSM_RST_PC;
				end
			end
			CSM_HWSTBY: next_state = CSM_HWSTBY;
			CSM_RST_PC: begin
				if (mem_ack) begin
					next_state = CSM_RST_SP;
				end
			end
			CSM_RST_SP: begin
				if (mem_ack) begin
					next_state = CSM_RUN;
				end
			end
			CSM_IRQ_PC: begin
				if (mem_ack) begin
					next_state = CSM_IRQ_SR;
				end
			end
			CSM_IRQ_SR: begin
				if (mem_ack) begin
					next_state = CSM_IRQ_VEC;
				end
			end
			CSM_IRQ_VEC: begin
				if (mem_ack) begin
					next_state = CSM_RUN;
				end
			end
			CSM_RUN: begin
				if (irq_req) begin
					next_state = CSM_IRQ_PC;
				end else if (bus_req) begin
					next_state = CSM_BUSREL;
				end else if (sleep_exec) begin
					next_state = standby_select ? CSM_SWSTBY : CSM_SLEEP;
				end
			end
			CSM_SLEEP, CSM_SWSTBY: begin
				if (irq_req || wake_event) begin
					next_state = irq_req ? CSM_IRQ_PC : CSM_RUN;
				end
			end
			CSM_BUSREL: begin
				if (!bus_req) begin
					next_state = CSM_RUN;
				end
			end
			default: next_state = CSM_POR;
		endcase
		if (!man_s && state != CSM_POR) begin
			next_state = CSM_MAN;
		end
		if (!por_s) begin
			next_state = hst_s ? CSM_POR : CSM_HWSTBY;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= CSM_POR;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_state <= 4'h0;
			por_active <= 1'b1;
			man_active <= 1'b0;
			hw_standby <= 1'b0;
			cpu_halt <= 1'b1;
			bus_grant <= 1'b0;
		end else begin
			cpu_state <= 4'(next_state);
			por_active <= next_state == CSM_POR;
			man_active <= next_state == CSM_MAN;
			hw_standby <= next_state == CSM_HWSTBY;
			cpu_halt <= next_state != CSM_RUN;
			bus_grant <= next_state == CSM_BUSREL;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			is_manual <= 1'b0;
		end else if (state == CSM_MAN) begin
			is_manual <= 1'b1;
		end else if (state == CSM_POR) begin
			is_manual <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 32'h0000_0000;
			mem_wdata <= 32'h0000_0000;
			load_regs <= 1'b0;
			new_pc <= 32'h0000_0000;
			new_sp <= 32'h0000_0000;
			new_vbr <= VBR_RESET;
			new_imask <= IMASK_RESET;
			sp_work <= 32'h0000_0000;
			pc_hold <= 32'h0000_0000;
		end else begin
			load_regs <= 1'b0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			case (next_state)
				CSM_RST_PC: begin
					mem_req <= 1'b1;
					mem_addr <= is_manual || state == CSM_MAN ? VEC_MAN_PC : VEC_POR_PC;
				end
				CSM_RST_SP: begin
					mem_req <= 1'b1;
					mem_addr <= is_manual ? VEC_MAN_SP : VEC_POR_SP;
				end
				CSM_IRQ_PC: begin
					mem_req <= 1'b1;
					mem_we <= 1'b1;
					mem_addr <= state == CSM_IRQ_PC ? mem_addr : sp_dec(sp_work);
					mem_wdata <= state == CSM_IRQ_PC ? mem_wdata : cpu_pc;
				end
				CSM_IRQ_SR: begin
					mem_req <= 1'b1;
					mem_we <= 1'b1;
					mem_addr <= state == CSM_IRQ_SR ? mem_addr : sp_dec(mem_addr);
					mem_wdata <= state == CSM_IRQ_SR ? mem_wdata : cpu_sr;
				end
				CSM_IRQ_VEC: begin
					mem_req <= 1'b1;
					mem_addr <= irq_vec_addr;
				end
				default: begin
				end
			endcase
			if (state == CSM_RST_PC && mem_ack) begin
				pc_hold <= mem_rdata;
			end
			if (state == CSM_IRQ_SR && mem_ack) begin
				sp_work <= mem_addr;
			end
			if (state == CSM_RST_SP && mem_ack) begin
				load_regs <= 1'b1;
				new_pc <= pc_hold;
				new_sp <= mem_rdata;
				sp_work <= mem_rdata;
				new_vbr <= VBR_RESET;
				new_imask <= IMASK_RESET;
			end
			if (state == CSM_IRQ_VEC && mem_ack) begin
				load_regs <= 1'b1;
				new_pc <= mem_rdata;
				new_sp <= sp_work;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			op_mode <= MODE_SINGLE;
			mode_invalid <= 1'b0;
			flash_wp <= 1'b0;
			clk_mul <= CLK_MUL1;
			cs0_external <= 1'b0;
			cs0_bus8 <= 1'b0;
			rom_enable <= 1'b1;
			ext_addr_enable <= 1'b0;
		end else if (state == CSM_POR) begin
			op_mode <= mode_s[1:0];
			flash_wp <= mode_s[4];
			clk_mul <= mode_s[3:2];
			mode_invalid <= mode_s[1:0] == MODE_EXT1 || mode_s[3:2] == 2'h3;
			cs0_external <= mode_s[1:0] == MODE_EXT0 || mode_s[1:0] == MODE_EXT2;
			cs0_bus8 <= mode_s[1:0] == MODE_EXT0;
			rom_enable <= mode_s[1:0] == MODE_EXT2 || mode_s[1:0] == MODE_SINGLE;
			ext_addr_enable <= mode_s[1:0] != MODE_SINGLE && mode_s[1:0] != MODE_EXT1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sys_div_clk <= '0;
			per_div_clk <= '0;
		end else begin
			sys_div_clk <= sys_div_clk + 1'b1;
			per_div_clk <= per_div_clk + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			module_standby <= MSTBY_RESET;
		end else begin
			module_standby <= module_standby & ~mstby_clear;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_prev <= 1'b0;
			osc_cnt <= '0;
			osc_halted <= 1'b0;
		end else begin
			osc_prev <= osc_s;
			if (osc_s != osc_prev) begin
				osc_cnt <= '0;
				osc_halted <= 1'b0;
			end else if (osc_cnt == OSC_CNT_W'(OSC_TIMEOUT)) begin
				osc_halted <= 1'b1;
			end else begin
				osc_cnt <= osc_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_pin_out <= '0;
			timer_pin_oe <= '0;
		end else begin
			timer_pin_out <= timer_out;
			if (osc_halted || state == CSM_SWSTBY || state == CSM_HWSTBY) begin
				timer_pin_oe <= '0;
			end else begin
				timer_pin_oe <= timer_oe_pfc;
			end
		end
	end
endmodule
`default_nettype wire

/* csm_pkg.sv */
package csm_pkg;
	localparam int VEC_W = 32;
	localparam logic [31:0] VEC_POR_PC = 32'h0000_0000;
	localparam logic [31:0] VEC_POR_SP = 32'h0000_0004;
	localparam logic [31:0] VEC_MAN_PC = 32'h0000_0008;
	localparam logic [31:0] VEC_MAN_SP = 32'h0000_000C;
	localparam logic [31:0] VBR_RESET = 32'h0000_0000;
	localparam logic [3:0] IMASK_RESET = 4'hF;
	localparam int SP_STEP = 4;
	localparam int TIMER_PINS = 12;
	localparam int SYS_DIV_W = 13;
	localparam int PER_DIV_W = 10;
	localparam int OSC_TIMEOUT = 16;
	localparam int OSC_CNT_W = 5;
	localparam int MSTBY_W = 8;
	localparam logic [7:0] MSTBY_RESET = 8'hFF;
	localparam logic [1:0] MODE_EXT0 = 2'h0;
	localparam logic [1:0] MODE_EXT1 = 2'h1;
	localparam logic [1:0] MODE_EXT2 = 2'h2;
	localparam logic [1:0] MODE_SINGLE = 2'h3;
	localparam logic [1:0] CLK_MUL1 = 2'h0;
	localparam logic [1:0] CLK_MUL2 = 2'h1;
	localparam logic [1:0] CLK_MUL4 = 2'h2;
	typedef enum logic [3:0] {
		CSM_POR, CSM_MAN, CSM_HWSTBY, CSM_RST_PC, CSM_RST_SP, CSM_IRQ_PC, CSM_IRQ_SR,
		CSM_IRQ_VEC, CSM_RUN, CSM_SLEEP, CSM_SWSTBY, CSM_BUSREL
	} csm_state_e;
endpackage

/* csm_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module csm_sync import csm_pkg::*; #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
			dout <= INIT;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			for (int i = 0; i < W; i++) begin
				if (s2[i] == s3[i]) begin
					dout[i] <= s3[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

/* csm_board_model.sv */
`timescale 1ns/1ps
`default_nettype none
module csm_board_model (
	input wire logic clk,
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	input wire logic slow,
	input wire logic osc_run,
	output logic mem_ack,
	output logic [31:0] mem_rdata,
	output logic osc_input
);
	logic [1:0] wait_cnt = 2'h0;
	logic [1:0] osc_div = 2'h0;
	initial mem_ack = 1'b0;
	initial mem_rdata = 32'h0000_0000;
	initial osc_input = 1'b0;
	// Memory answers after 0 or 2 wait cycles; idle data toggles
	// Oscillator level holds four cycles so the three-flop filter can see it
	always @(posedge clk) begin
		if (osc_run) begin
			osc_div <= osc_div + 2'h1;
			if (osc_div == 2'h3)
				osc_input <= ~osc_input;
		end
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack) begin
			if (wait_cnt == (slow ? 2'h2 : 2'h0)) begin
				mem_ack <= 1'b1;
				mem_rdata <= mem_addr + 32'h1000_0000;
				wait_cnt <= 2'h0;
			end else
				wait_cnt <= wait_cnt + 2'h1;
		end
	end
endmodule
`default_nettype wire

/* csm_ctrl_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module csm_ctrl_checker import csm_pkg::*; (
	input wire logic clk,
	input wire logic power_on_clear_n,
	input wire logic hw_standby_n,
	input wire logic sleep_exec,
	input wire logic standby_select,
	input wire logic irq_req,
	input wire logic bus_req,
	input wire logic mem_ack,
	input wire logic [3:0] cpu_state,
	input wire logic por_active,
	input wire logic hw_standby,
	input wire logic cpu_halt,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic load_regs,
	input wire logic [31:0] new_vbr,
	input wire logic [3:0] new_imask,
	input wire logic bus_grant,
	input wire logic [1:0] op_mode,
	input wire logic mode_invalid,
	input wire logic cs0_external,
	input wire logic cs0_bus8,
	input wire logic ext_addr_enable,
	input wire logic [1:0] clk_mul,
	input wire logic [SYS_DIV_W-1:0] sys_div_clk,
	input wire logic [TIMER_PINS-1:0] timer_pin_oe,
	input wire logic osc_halted
);
	wire rstn = power_on_clear_n | ~hw_standby_n;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_fetch(logic [31:0] a);
		mem_req && mem_ack && !mem_we && mem_addr == a;
	endsequence
	a_por_vec_order: assert property (s_fetch(VEC_POR_PC) |=> ##[0:2]
		mem_req && mem_addr == VEC_POR_SP) else $error("power-on vector order");
	a_man_vec_order: assert property (s_fetch(VEC_MAN_PC) |=> ##[0:2]
		mem_req && mem_addr == VEC_MAN_SP) else $error("manual vector order");
	a_reset_load_vals: assert property (s_fetch(VEC_POR_SP) or s_fetch(VEC_MAN_SP) |->
		##[1:3] load_regs && new_vbr == VBR_RESET && new_imask == IMASK_RESET)
		else $error("reset load values");
	a_sleep_halt: assert property (cpu_state == CSM_RUN && sleep_exec && !irq_req && !bus_req
		|=> cpu_halt && cpu_state == ($past(standby_select) ? CSM_SWSTBY : CSM_SLEEP))
		else $error("sleep entry");
	a_bus_grant: assert property (cpu_state == CSM_RUN && bus_req && !irq_req |=> bus_grant)
		else $error("bus not granted");
	a_mode_decode_ok: assert property ((op_mode != MODE_EXT0 || cs0_external && cs0_bus8)
		&& (op_mode != MODE_EXT1 && clk_mul != 2'h3 || mode_invalid)
		&& (op_mode != MODE_SINGLE || !ext_addr_enable)) else $error("mode decode");
	a_mode_latched: assert property (!por_active && !$past(por_active) |->
		$stable(op_mode) && $stable(clk_mul)) else $error("mode changed after reset");
	a_timer_float: assert property ((osc_halted || hw_standby || cpu_state == CSM_SWSTBY) [*2]
		|-> timer_pin_oe == '0) else $error("timer pins driven");
	a_div_count: assert property (sys_div_clk != '0 && !hw_standby |=> hw_standby ||
		sys_div_clk == $past(sys_div_clk) + 13'h1) else $error("divider stalled");
endmodule
bind csm_ctrl csm_ctrl_checker u_csm_ctrl_checker (.*);
`default_nettype wire

/* cpu_state_and_mode_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_state_and_mode_control_tb_top import csm_pkg::*;;
	localparam logic [31:0] OFS = 32'h1000_0000;
	logic clk, power_on_clear_n = 1'b0, manual_clear_n = 1'b1, hw_standby_n = 1'b1;
	logic flash_write_protect = 1'b0, sleep_exec = 1'b0, standby_select = 1'b0;
	logic wake_event = 1'b0, irq_req = 1'b0, bus_req = 1'b0, slow = 1'b0, osc_run = 1'b1;
	logic [3:0] mode_select_pins = 4'h0;
	logic [31:0] irq_vec_addr = 32'h0000_0100, cpu_pc = 32'h0000_2468, cpu_sr = 32'h0000_00F0;
	logic [MSTBY_W-1:0] mstby_clear = 8'h00;
	logic [TIMER_PINS-1:0] timer_out = 12'hA5C, timer_oe_pfc = 12'hF0F;
	logic osc_input, mem_ack, por_active, man_active, hw_standby, cpu_halt, mem_req, mem_we;
	logic load_regs, bus_grant, mode_invalid, flash_wp, cs0_external, cs0_bus8, rom_enable;
	logic ext_addr_enable, osc_halted;
	logic [3:0] cpu_state, new_imask;
	logic [31:0] mem_rdata, mem_addr, mem_wdata, new_pc, new_sp, new_vbr;
	logic [1:0] op_mode, clk_mul;
	logic [SYS_DIV_W-1:0] sys_div_clk;
	logic [PER_DIV_W-1:0] per_div_clk;
	logic [MSTBY_W-1:0] module_standby;
	logic [TIMER_PINS-1:0] timer_pin_out, timer_pin_oe;
	logic [10:0] rows [5] = '{11'h000, 11'h2D9, 11'h64B, 11'h325, 11'h5B6};
	logic [63:0] wq [$];
	int mismatches = 0;
	int check_count = 0;
	logic [SYS_DIV_W-1:0] div_ref;
	csm_ctrl u_csm_ctrl (.*);
	csm_board_model u_csm_board_model (.*);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
		if (mem_req && mem_ack && mem_we)
			wq.push_back({mem_addr, mem_wdata});
	task chk(input logic ok, input string what);
		check_count++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task look(input int n);
		tick(n);
		@(negedge clk);
	endtask
	task wait_load;
		for (int i = 0; i < 300 && load_regs !== 1'b1; i++)
			@(negedge clk);
		chk(load_regs === 1'b1, "no register load");
	endtask
	task boot(input logic [3:0] pins, input logic wp);
		@(posedge clk);
		power_on_clear_n <= 1'b0;
		mode_select_pins <= pins;
		flash_write_protect <= wp;
		look(16);
		chk(por_active === 1'b1 && cpu_halt === 1'b1, "power-on state");
		chk(module_standby === MSTBY_RESET && timer_pin_oe === '0, "reset outputs");
		@(posedge clk);
		power_on_clear_n <= 1'b1;
		wait_load();
		chk(new_pc === VEC_POR_PC + OFS && new_sp === VEC_POR_SP + OFS, "por vectors");
		chk(new_vbr === VBR_RESET && new_imask === IMASK_RESET, "vbr and mask");
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		foreach (rows[i]) begin
			boot(rows[i][10:7], rows[i][6]);
			chk(op_mode === rows[i][5:4] && mode_invalid === rows[i][3], "mode");
			chk(rom_enable === rows[i][2] && flash_wp === rows[i][6], "rom or wp");
			chk(rows[i][3] || clk_mul === rows[i][1:0], "clock multiplier");
			chk(cs0_external === (rows[i][5:4] == MODE_EXT0 || rows[i][5:4] == MODE_EXT2)
				&& cs0_bus8 === (rows[i][5:4] == MODE_EXT0)
				&& ext_addr_enable === cs0_external, "area zero and address");
		end
		$display("test mode table done");
		@(posedge clk);
		slow <= 1'b1;
		manual_clear_n <= 1'b0;
		look(8);
		chk(man_active === 1'b1, "manual state");
		@(posedge clk);
		manual_clear_n <= 1'b1;
		wait_load();
		chk(new_pc === VEC_MAN_PC + OFS && new_sp === VEC_MAN_SP + OFS, "manual vectors");
		tick(4);
		irq_req <= 1'b1;
		tick(1);
		irq_req <= 1'b0;
		wait_load();
		chk(new_pc === irq_vec_addr + OFS, "service address");
		chk(wq.size() == 2 && wq[0] === {VEC_MAN_SP + OFS - 32'h4, cpu_pc}
			&& wq[1] === {VEC_MAN_SP + OFS - 32'h8, cpu_sr}, "stack pushes");
		tick(4);
		bus_req <= 1'b1;
		look(1);
		chk(bus_grant === 1'b1, "bus grant");
		@(posedge clk);
		bus_req <= 1'b0;
		look(1);
		chk(bus_grant === 1'b0, "bus return");
		$display("test reset irq bus done");
		for (int s = 0; s < 2; s++) begin
			tick(3);
			standby_select <= s[0];
			sleep_exec <= 1'b1;
			tick(1);
			sleep_exec <= 1'b0;
			@(negedge clk);
			chk(cpu_halt === 1'b1 && cpu_state === (s ? CSM_SWSTBY : CSM_SLEEP), "sleep");
			look(3);
			chk(s == 0 || timer_pin_oe === '0, "standby pins");
			@(posedge clk);
			wake_event <= 1'b1;
			tick(1);
			wake_event <= 1'b0;
			look(4);
			chk(!cpu_halt && timer_pin_oe === timer_oe_pfc && timer_pin_out === timer_out, "wake");
		end
		@(posedge clk);
		mstby_clear <= 8'h81;
		tick(1);
		mstby_clear <= 8'h00;
		look(2);
		chk(module_standby === 8'h7E, "module standby clear");
		div_ref = sys_div_clk;
		look(5);
		chk(sys_div_clk === div_ref + 13'h5 && per_div_clk === div_ref[9:0] + 10'h5, "dividers");
		@(posedge clk);
		osc_run <= 1'b0;
		look(30);
		chk(osc_halted === 1'b1 && timer_pin_oe === '0, "oscillator halt");
		@(posedge clk);
		osc_run <= 1'b1;
		hw_standby_n <= 1'b0;
		power_on_clear_n <= 1'b0;
		look(8);
		chk(hw_standby === 1'b1 && timer_pin_oe === '0, "hardware standby");
		@(posedge clk);
		hw_standby_n <= 1'b1;
		look(2);
		chk(por_active === 1'b1, "power-on from standby");
		$display("test power-down done");
		test_done();
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		test_done();
	end
endmodule
`default_nettype wire
